// ### logic/rsro_core.sv
// execute slice for relative call, software reset and interrupt return
// assumes instruction words are presented on i_instr with i_instr_valid
// at the first quarter of a cycle; shadow context is supplied on i_shadow
// i_shadow and i_irq_high_prio must hold steady up to the fourth quarter,
// where an interrupt return samples them
// four clocks of i_clk_sys make one instruction cycle, no slower clock
//
// What this block does
// - relative call leaves target in pc, return address on stack top unless the stack is full
// - software reset returns all master clear affected state to reset
// - software reset recognised from opcode 16'h00FF, no operands
// - interrupt return pops the stack and loads top value into pc
// - interrupt return sets high or low global enable, nothing else
// - fast select set: shadow working, status, bank copied back
// - fast select clear: working, status and bank left unchanged
// - interrupt return takes two cycles, pop and enable in fourth quarter
module rsro_core
(
  input  wire logic                      i_clk_sys,
  input  wire logic                      i_rst_n,
  input  wire logic [15:0]               i_instr,
  input  wire logic                      i_instr_valid,
  input  wire logic                      i_irq_high_prio,
  input  wire rsro_pkg::rsro_ctx_t       i_shadow,
  output logic      [rsro_pkg::PC_W-1:0] o_pc,
  output logic      [rsro_pkg::PC_W-1:0] o_top_of_stack,
  output rsro_pkg::rsro_ctx_t            o_ctx,
  output logic                           o_high_priority_global_enable,
  output logic                           o_low_priority_global_enable,
  output logic                           o_master_clear_reset,
  output logic      [1:0]                o_qphase,
  output logic                           o_busy
);

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic is_soft_reset(input logic [15:0] op);
    is_soft_reset = (op == rsro_pkg::RESET_OPCODE);
  endfunction : is_soft_reset

  function automatic logic is_ret_int(input logic [15:0] op);
    is_ret_int = ((op & rsro_pkg::RETINT_MASK) == rsro_pkg::RETINT_MATCH);
  endfunction : is_ret_int

  function automatic logic is_rel_call(input logic [15:0] op);
    is_rel_call = (op[15:11] == rsro_pkg::CALL_MATCH);
  endfunction : is_rel_call

  // fast select picks the shadow copy, otherwise the live set stays
  function automatic rsro_pkg::rsro_ctx_t pick_ctx
  (
    input logic                fast,
    input rsro_pkg::rsro_ctx_t shadow,
    input rsro_pkg::rsro_ctx_t live
  );
    pick_ctx = fast ? shadow : live;
  endfunction : pick_ctx

  // master clear value of every field; pin and soft reset share it
  function automatic rsro_pkg::rsro_regs_t reset_regs();
    reset_regs.state     = rsro_pkg::RSRO_ST_FETCH;
    reset_regs.qph       = rsro_pkg::Q_RESET;
    reset_regs.pc        = rsro_pkg::PC_RESET;
    reset_regs.sp        = rsro_pkg::SP_RESET;
    reset_regs.ctx       = '{rsro_pkg::BYTE_RESET, rsro_pkg::BYTE_RESET,
                             rsro_pkg::BYTE_RESET};
    reset_regs.hp_enable = 1'b0;
    reset_regs.lp_enable = 1'b0;
    reset_regs.soft_rst  = 1'b0;
    reset_regs.op        = rsro_pkg::OP_RESET;
  endfunction : reset_regs

  ////////////////////////////////////////////////////////////////////////////
  // state and return stack

  // thirty one return slots; the pointer counts occupied entries, so
  // full and empty are both plain compares on it
  rsro_pkg::rsro_regs_t      st_reg;
  rsro_pkg::rsro_regs_t      st_next;
  logic [rsro_pkg::PC_W-1:0] stack_reg [rsro_pkg::STK_D];
  logic                      push;
  logic                      push_ok;
  logic [rsro_pkg::PC_W-1:0] push_val;
  logic [rsro_pkg::PC_W-1:0] stack_top;
  logic [rsro_pkg::PC_W-1:0] offs;
  logic                      stack_empty;
  logic                      stack_full;
  logic                      at_q4;
  logic                      at_q1;
  logic                      take;

  // an empty stack reads back zero rather than a stale entry
  assign stack_empty = (st_reg.sp == rsro_pkg::SP_RESET);
  assign stack_full  = (st_reg.sp == 5'(rsro_pkg::STK_D));
  assign stack_top   = stack_empty ? rsro_pkg::PC_RESET
                       : stack_reg[st_reg.sp - 5'h01];

  // quarter phase decode
  assign at_q4 = (st_reg.qph == rsro_pkg::Q_LAST);
  assign at_q1 = (st_reg.qph == rsro_pkg::Q_RESET);
  // words are only taken at the first quarter of a fetch cycle
  assign take  = at_q1 && (st_reg.state == rsro_pkg::RSRO_ST_FETCH);
  // 2n as a sign extended byte offset
  assign offs  = {{(rsro_pkg::PC_W-12){st_reg.op[10]}}, st_reg.op[10:0],
                  1'b0};

  // return address pushed in the second quarter of a call
  assign push     = (st_reg.state == rsro_pkg::RSRO_ST_FETCH)
                    && (st_reg.qph == rsro_pkg::Q_PUSH)
                    && is_rel_call(st_reg.op);
  assign push_val = st_reg.pc + rsro_pkg::PC_STEP;
  // a push onto a full stack is dropped rather than wrapping over slot 0
  assign push_ok  = push && !stack_full;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  // a word is taken at the first quarter and its result lands at the
  // fourth, so every result but the call's stack push shows at the quarter
  // wrap; the soft reset is the other exception, as it must start before the cycle ends
  always_comb
  begin
    st_next          = st_reg;
    st_next.qph      = st_reg.qph + 2'h1;
    st_next.soft_rst = 1'b0;
    // latch the word once per fetch cycle; an invalid word runs as a no-op
    if (take)
      st_next.op = i_instr_valid ? i_instr : rsro_pkg::OP_RESET;
    unique case (st_reg.state)
      rsro_pkg::RSRO_ST_FETCH:
      begin
        if (take && i_instr_valid && is_soft_reset(i_instr))
          st_next.soft_rst = 1'b1;
        if (at_q4)
        begin
          if (is_rel_call(st_reg.op))
          begin
            st_next.pc    = st_reg.pc + rsro_pkg::PC_STEP + offs;
            st_next.state = rsro_pkg::RSRO_ST_IDLE2;
          end
          else if (is_ret_int(st_reg.op))
          begin
            // pop into pc; an empty stack keeps sp at zero
            st_next.pc = stack_top;
            if (!stack_empty)
              st_next.sp = st_reg.sp - 5'h01;
            if (i_irq_high_prio)
              st_next.hp_enable = 1'b1;
            else
              st_next.lp_enable = 1'b1;
            st_next.ctx = pick_ctx(st_reg.op[0], i_shadow, st_reg.ctx);
            st_next.state = rsro_pkg::RSRO_ST_IDLE2;
          end
          else
            st_next.pc = st_reg.pc + rsro_pkg::PC_STEP;
        end
      end
      rsro_pkg::RSRO_ST_IDLE2:
      begin
        // idle cycle; words offered now are ignored
        if (at_q4)
          st_next.state = rsro_pkg::RSRO_ST_FETCH;
      end
      default:
      begin
        // an unused code falls back to fetch rather than locking up
        st_next.state = rsro_pkg::RSRO_ST_FETCH;
      end
    endcase
    if (push_ok)
      st_next.sp = st_reg.sp + 5'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  // soft reset acts like the master clear pin one clock later, so the
  // pulse is seen outside before the state is wiped
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n || st_reg.soft_rst)
      st_reg <= reset_regs();
    else
      st_reg <= st_next;
  end

  // stack array has no reset: only the pointer says which slots count
  always_ff @(posedge i_clk_sys)
  begin
    if (push_ok)
      stack_reg[st_reg.sp] <= push_val;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  // every output is a register field except busy, a decode of the state,
  // and the stack top, which is a read of the array just below the pointer
  assign o_pc                          = st_reg.pc;
  assign o_top_of_stack                = stack_top;
  assign o_ctx                         = st_reg.ctx;
  assign o_high_priority_global_enable = st_reg.hp_enable;
  assign o_low_priority_global_enable  = st_reg.lp_enable;
  assign o_master_clear_reset          = st_reg.soft_rst;
  assign o_qphase                      = st_reg.qph;
  // busy through the whole idle second cycle
  assign o_busy = (st_reg.state == rsro_pkg::RSRO_ST_IDLE2);

endmodule : rsro_core

// ### logic/rsro_pkg.sv
// package for the return and soft reset execute block
// assumes a core clock split into four quarter phases by the block itself
package rsro_pkg;

  localparam int PC_W  = 21;
  localparam int STK_D = 31;
  localparam int SP_W  = 5;

  // opcode of the software reset instruction
  localparam logic [15:0] RESET_OPCODE = 16'h00FF;
  // return from interrupt: all zeros except bit 4, bit 0 is fast select
  localparam logic [15:0] RETINT_MASK  = 16'hFFFE;
  localparam logic [15:0] RETINT_MATCH = 16'h0010;
  // relative call: upper five bits 11011, eleven bit signed offset
  localparam logic [4:0]  CALL_MATCH   = 5'h1B;

  // reset values, plus the last and push quarter codes
  localparam logic [PC_W-1:0] PC_RESET   = 21'h000000;
  localparam logic [SP_W-1:0] SP_RESET   = 5'h00;
  localparam logic [7:0]      BYTE_RESET = 8'h00;
  localparam logic [1:0]      Q_RESET    = 2'h0;
  localparam logic [1:0]      Q_LAST     = 2'h3;
  localparam logic [1:0]      Q_PUSH     = 2'h1;
  localparam logic [15:0]     OP_RESET   = 16'h0000;
  // program counter step for one instruction word
  localparam logic [PC_W-1:0] PC_STEP    = 21'h000002;

  // core execution state
  typedef enum logic [1:0]
  {
    RSRO_ST_FETCH = 2'b00,
    RSRO_ST_IDLE2 = 2'b01
  } rsro_state_t;

  // fast restore working set
  typedef struct packed
  {
    logic [7:0] wreg;
    logic [7:0] status;
    logic [7:0] bank;
  } rsro_ctx_t;

  // all state of the block except the return stack array
  typedef struct packed
  {
    rsro_state_t     state;
    logic [1:0]      qph;
    logic [PC_W-1:0] pc;
    logic [SP_W-1:0] sp;
    rsro_ctx_t       ctx;
    logic            hp_enable;
    logic            lp_enable;
    logic            soft_rst;
    logic [15:0]     op;
  } rsro_regs_t;

endpackage : rsro_pkg

// ### sim/rsro_core_chk.sv
// checker for the return and soft reset execute block
// assumes it is bound to rsro_core and sees only its ports
module rsro_core_chk
(
  input logic                i_clk_sys,
  input logic                i_rst_n,
  input logic [15:0]         i_instr,
  input logic                i_instr_valid,
  input logic                i_irq_high_prio,
  input rsro_pkg::rsro_ctx_t i_shadow,
  input logic [20:0]         o_pc,
  input logic [20:0]         o_top_of_stack,
  input rsro_pkg::rsro_ctx_t o_ctx,
  input logic                o_high_priority_global_enable,
  input logic                o_low_priority_global_enable,
  input logic                o_master_clear_reset,
  input logic [1:0]          o_qphase,
  input logic                o_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  // decode of a word the core really takes
  wire take = o_qphase == 2'h0 && !o_busy && i_instr_valid;
  wire ret  = take && (i_instr & rsro_pkg::RETINT_MASK) == 16'h0010;
  wire call = take && i_instr[15:11] == rsro_pkg::CALL_MATCH;
  wire sres = take && i_instr == rsro_pkg::RESET_OPCODE;
  a_ret_pc_pop: assert property (ret |-> ##4
    o_pc == $past(o_top_of_stack, 4)) else $error("pc not popped");
  a_ret_fast_ctx: assert property (ret && i_instr[0] |-> ##4
    o_ctx == $past(i_shadow, 4)) else $error("shadow not restored");
  a_ret_keep_ctx: assert property (ret && !i_instr[0] |-> ##4
    o_ctx == $past(o_ctx, 4)) else $error("context changed");
  a_ret_enable_set: assert property (ret |-> ##4 (i_irq_high_prio ?
    o_high_priority_global_enable : o_low_priority_global_enable))
    else $error("enable not set");
  a_ret_idle_cycle: assert property (ret |-> ##4
    o_busy[*4] ##1 !o_busy) else $error("idle cycle wrong");
  a_call_target: assert property (call |-> ##4 o_pc == 21'($past(o_pc, 4)
    + 21'h2 + {{9{$past(i_instr[10], 4)}}, $past(i_instr[10:0], 4), 1'b0}))
    else $error("call target wrong");
  a_soft_reset: assert property (sres |=> o_master_clear_reset ##1
    (o_pc == 21'h0 && o_ctx == 24'h0 && !o_busy && o_qphase == 2'h0 &&
     o_top_of_stack == 21'h0 && !o_high_priority_global_enable &&
     !o_low_priority_global_enable)) else $error("soft reset incomplete");
  a_pulse_cause: assert property ($rose(o_master_clear_reset) |->
    $past(sres)) else $error("spurious reset pulse");
  cover property (ret && i_instr[0]);
  cover property (call);
  cover property (sres);
endmodule : rsro_core_chk
////////////////////////////////////////////////////////////////////////////
bind rsro_core rsro_core_chk chk_u (.*);

// ### sim/rsro_core_tb.sv
// bench for rsro_core: integer model compared after every instruction
// assumes rsro_pkg, rsro_core and the checker are compiled first
module rsro_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk_sys, i_rst_n, i_instr_valid, i_irq_high_prio;
  logic o_high_priority_global_enable, o_low_priority_global_enable;
  logic o_master_clear_reset, o_busy;
  logic [15:0] i_instr, op;
  logic [20:0] o_pc, o_top_of_stack;
  logic [1:0] o_qphase;
  rsro_pkg::rsro_ctx_t i_shadow, o_ctx;
  int err_total, cmp_count, pc, gh, gl, ctx, k;
  int stk[$];
  logic [15:0] dir[6] = '{16'hDBFF, 16'h0011, 16'h00FE, 16'h01FF,
                          16'hDC00, 16'h00FF};
  rsro_core dut_u (.*);
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  task automatic chk(input logic [23:0] s, e);
    cmp_count++;
    if (s !== e)
    begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic end_sim();
    $display("compares=%0d mismatches=%0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim
  // one instruction at a free Q1, model stepped, then all results compared
  task automatic issue(input logic [15:0] w, input logic v);
    int n;
    int i;
    logic p;
    int cyc;
    i_instr = w;
    i_instr_valid = v;
    i_irq_high_prio = 1'($urandom);
    i_shadow = 24'($urandom);
    n = w[10] ? int'(w[10:0]) - 2048 : int'(w[10:0]);
    p = 1'b0;
    i = 0;
    // plain words take one cycle, call and return two, soft reset half
    cyc = 4;
    if (v && w[15:11] == rsro_pkg::CALL_MATCH)
    begin
      cyc = 8;
      // stack full: the push is dropped, not wrapped
      if (stk.size() < 31)
        stk.push_back((pc + 2) & 'h1FFFFF);
      pc = (pc + 2 + 2 * n) & 'h1FFFFF;
    end
    else if (v && (w & 16'hFFFE) == 16'h0010)
    begin
      cyc = 8;
      pc = stk.size() ? stk.pop_back() : 0;
      gh |= i_irq_high_prio;
      gl |= !i_irq_high_prio;
      ctx = w[0] ? i_shadow : ctx;
    end
    else if (v && w == 16'h00FF)
    begin
      cyc = 2;
      stk.delete();
      {pc, gh, gl, ctx} = '0;
    end
    else
      pc = (pc + 2) & 'h1FFFFF;
    do
    begin
      @(negedge i_clk_sys);
      p |= o_master_clear_reset;
      i++;
    end
    while ((o_qphase !== 2'h0 || o_busy !== 1'b0) && i < 20);
    chk(o_pc, pc);
    chk(o_top_of_stack, stk.size() ? stk[$] : 0);
    chk(o_ctx, ctx);
    chk({o_high_priority_global_enable, o_low_priority_global_enable},
        {gh[0], gl[0]});
    chk(p, v && w == 16'h00FF);
    chk(24'(i), 24'(cyc));
  endtask : issue
  initial
  begin
    i_rst_n = 1'b0;
    i_instr = 16'h0000;
    i_instr_valid = 1'b1;
    i_irq_high_prio = 1'b0;
    i_shadow = '0;
    {err_total, cmp_count, pc, gh, gl, ctx} = '0;
    void'($urandom(45449));
    repeat (5) @(negedge i_clk_sys);
    i_rst_n = 1'b1;
    // overfill the stack, then pop past empty, then edge opcodes
    repeat (33) issue(16'hD800, 1'b1);
    repeat (33) issue(16'h0011, 1'b1);
    foreach (dir[j]) issue(dir[j], 1'b1);
    $display("directed test done");
    repeat (300)
    begin
      k = $urandom % 6;
      case (k)
        0: op = {5'h1B, 11'($urandom)};
        1, 2: op = 16'h0010 | 16'(k - 1);
        3: op = 16'h00FF;
        default: op = {4'h2, 12'($urandom)};
      endcase
      issue(op, ($urandom % 8) != 0);
    end
    $display("random test done");
    end_sim();
  end
  initial
  begin
    #200000;
    err_total++;
    end_sim();
  end
endmodule : rsro_core_tb
